// ### core/dmarep_defines.vh
`ifndef DMAREP_DEFINES_VH
`define DMAREP_DEFINES_VH

// register byte offsets
`define DMAREP_OFS_CTRL     8'h00
`define DMAREP_OFS_MEMPTR   8'h04
`define DMAREP_OFS_IOLOW    8'h08
`define DMAREP_OFS_LIVECNT  8'h0c
`define DMAREP_OFS_INITCNT  8'h10
`define DMAREP_OFS_SRCPTR   8'h14
`define DMAREP_OFS_DSTPTR   8'h18
`define DMAREP_OFS_PAIRCNT  8'h1c
`define DMAREP_OFS_STATUS   8'h20

// control register fields
`define DMAREP_CTL_EN       0
`define DMAREP_CTL_IRQEN    1
`define DMAREP_CTL_WORD     2
`define DMAREP_CTL_DEC      3
`define DMAREP_CTL_REPEAT   4
`define DMAREP_CTL_SRC_LO   5
`define DMAREP_CTL_SRC_HI   7
`define DMAREP_CTL_BURST    8
`define DMAREP_CTL_SST_LO   9
`define DMAREP_CTL_SST_HI   10
`define DMAREP_CTL_DST_LO   11
`define DMAREP_CTL_DST_HI   12
`define DMAREP_CTL_W        13
`define DMAREP_CTL_RST      13'h0000

// status register fields
`define DMAREP_ST_DONE      0
`define DMAREP_ST_BUSY      1

// activation sources
`define DMAREP_SRC_TX       3'h4
`define DMAREP_SRC_RX       3'h5
`define DMAREP_SRC_EXT      3'h6
`define DMAREP_SRC_AUTO     3'h7

// pointer step codes
`define DMAREP_STEP_HOLD    2'h0
`define DMAREP_STEP_INC     2'h1
`define DMAREP_STEP_DEC     2'h2

// fixed upper part of the io address
`define DMAREP_IO_HIGH      16'hffff

// axi responses
`define DMAREP_RESP_OKAY    2'h0
`define DMAREP_RESP_SLVERR  2'h2

`endif

// ### core/dmarep_channel.v
// Function
// - repeat mode chosen per channel by own bit
// - one byte or word per accepted request
// - receive-full copies io to memory, else reverse
// - repeat memory pointer steps by size, direction
// - io address is ffff plus low byte
// - live count decrements, reloads from initial count
// - reload restores pointer by count times size
// - repeat cycles until disabled, no interrupt
// - re-enable resumes from preserved state
// - cycle length up to 255 transfers
// - repeat accepts timer, serial, external requests
// - normal mode moves source to destination pointer
// - source, destination pointers step independently
// - normal count ends, clears enable, interrupts
// - normal count zero gives 65536 transfers
// - normal mode accepts only external or auto
// - cycle-steal releases bus after each transfer
// - burst with auto source holds bus unless higher master asks
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dmarep_defines.vh"

module dmarep_channel (
   input  wire        clk,
   input  wire        arst_n,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [3:0]  timerMatch,
   input  wire        txEmpty,
   input  wire        rxFull,
   input  wire        extReq_n,
   output reg         busReq,
   input  wire        busGrant,
   input  wire        hiPriReq,
   output reg         memReq,
   output reg         memWrite,
   output reg         memWord,
   output reg  [23:0] memAddr,
   output reg  [15:0] memWdata,
   input  wire        memAck,
   input  wire [15:0] memRdata,
   output reg         irqReq
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function [23:0] stepPtr;
      input [23:0] ptr;
      input [1:0]  step;
      input        word;
      reg   [23:0] sz;
      begin
         sz = word ? 24'h000002 : 24'h000001;
         case (step)
            `DMAREP_STEP_INC: stepPtr = ptr + sz;
            `DMAREP_STEP_DEC: stepPtr = ptr - sz;
            default:          stepPtr = ptr;
         endcase
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  strb;
      integer      i;
      begin
         for (i = 0; i < 4; i = i + 1)
            merge[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_ARB  = 4'h2;
   localparam [3:0] ST_RD   = 4'h4;
   localparam [3:0] ST_WR   = 4'h8;

   // ****************************************************************
   // registers
   // ****************************************************************
   reg [`DMAREP_CTL_W-1:0] ctrl_q;
   reg [23:0] memPtr_q;
   reg [7:0]  ioLow_q;
   reg [7:0]  liveCnt_q;
   reg [7:0]  initCnt_q;
   reg [23:0] srcPtr_q;
   reg [23:0] dstPtr_q;
   reg [15:0] pairCnt_q;
   reg        done_q;
   reg [3:0]  state_q;
   reg        pend_q;
   reg        fromRx_q;
   reg [2:0]  extSync_q;
   reg        extLvl_q;
   reg        awHave_q;
   reg        wHave_q;
   reg [7:0]  awAddr_q;
   reg [31:0] wData_q;
   reg [3:0]  wStrb_q;

   wire       en      = ctrl_q[`DMAREP_CTL_EN];
   wire       word    = ctrl_q[`DMAREP_CTL_WORD];
   wire       rep     = ctrl_q[`DMAREP_CTL_REPEAT];
   wire       burst   = ctrl_q[`DMAREP_CTL_BURST];
   wire [2:0] srcSel  = ctrl_q[`DMAREP_CTL_SRC_HI:`DMAREP_CTL_SRC_LO];
   wire [1:0] repStep = ctrl_q[`DMAREP_CTL_DEC] ? `DMAREP_STEP_DEC
                                                 : `DMAREP_STEP_INC;
   wire [23:0] ioAddr = {`DMAREP_IO_HIGH, ioLow_q};

   // ****************************************************************
   // request selection
   // ****************************************************************
   // falling edge only after the 2nd and 3rd stage agree, so glitches
   // shorter than a cycle never start a transfer
   wire extFall = extLvl_q & (extSync_q[2:1] == 2'b00);
   reg  trig;
   always @* begin
      trig = 1'b0;
      if (rep) begin
         case (srcSel)
            `DMAREP_SRC_TX:  trig = txEmpty;
            `DMAREP_SRC_RX:  trig = rxFull;
            `DMAREP_SRC_EXT: trig = extFall;
            `DMAREP_SRC_AUTO: trig = 1'b0;
            default:         trig = timerMatch[srcSel[1:0]];
         endcase
      end else begin
         case (srcSel)
            `DMAREP_SRC_EXT:  trig = extFall;
            `DMAREP_SRC_AUTO: trig = 1'b1;
            default:          trig = 1'b0;
         endcase
      end
   end

   wire startXfer = state_q[2] == 1'b0 && state_q[3] == 1'b0 &&
                    busGrant && busReq && (state_q == ST_ARB);
   wire lastDone  = state_q == ST_WR && memAck && memReq;
   wire normEnd   = !rep && pairCnt_q == 16'h0001;
   wire stayBus   = burst && !rep && !normEnd && !hiPriReq && en &&
                    srcSel == `DMAREP_SRC_AUTO;

   // ****************************************************************
   // axi-lite slave
   // ****************************************************************
   wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
   wire wrHit   = awAddr_q <= `DMAREP_OFS_STATUS && awAddr_q[1:0] == 2'b00;
   wire arHit   = s_axi_araddr <= `DMAREP_OFS_STATUS &&
                  s_axi_araddr[1:0] == 2'b00;
   wire [31:0] ctlM = merge({19'h00000, ctrl_q}, wData_q, wStrb_q);
   wire [31:0] memM = merge({8'h00, memPtr_q}, wData_q, wStrb_q);
   wire [31:0] srcM = merge({8'h00, srcPtr_q}, wData_q, wStrb_q);
   wire [31:0] dstM = merge({8'h00, dstPtr_q}, wData_q, wStrb_q);
   wire [31:0] cntM = merge({16'h0000, pairCnt_q}, wData_q, wStrb_q);
   reg [31:0] rdMux;
   always @* begin
      case (s_axi_araddr)
         `DMAREP_OFS_CTRL:    rdMux = {19'h00000, ctrl_q};
         `DMAREP_OFS_MEMPTR:  rdMux = {8'h00, memPtr_q};
         `DMAREP_OFS_IOLOW:   rdMux = {24'h000000, ioLow_q};
         `DMAREP_OFS_LIVECNT: rdMux = {24'h000000, liveCnt_q};
         `DMAREP_OFS_INITCNT: rdMux = {24'h000000, initCnt_q};
         `DMAREP_OFS_SRCPTR:  rdMux = {8'h00, srcPtr_q};
         `DMAREP_OFS_DSTPTR:  rdMux = {8'h00, dstPtr_q};
         `DMAREP_OFS_PAIRCNT: rdMux = {16'h0000, pairCnt_q};
         `DMAREP_OFS_STATUS:  rdMux = {30'h00000000, state_q != ST_IDLE,
                                       done_q};
         default:             rdMux = 32'h00000000;
      endcase
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `DMAREP_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `DMAREP_RESP_OKAY;
         s_axi_rdata   <= 32'h00000000;
         awHave_q      <= 1'b0;
         wHave_q       <= 1'b0;
         awAddr_q      <= 8'h00;
         wData_q       <= 32'h00000000;
         wStrb_q       <= 4'h0;
      end else begin
         s_axi_awready <= !awHave_q && !s_axi_awready;
         s_axi_wready  <= !wHave_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? `DMAREP_RESP_OKAY : `DMAREP_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHave_q     <= 1'b0;
            wHave_q      <= 1'b0;
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= arHit ? `DMAREP_RESP_OKAY : `DMAREP_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // transfer engine and register file
   // ****************************************************************
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q    <= `DMAREP_CTL_RST;
         memPtr_q  <= 24'h000000;
         ioLow_q   <= 8'h00;
         liveCnt_q <= 8'h00;
         initCnt_q <= 8'h00;
         srcPtr_q  <= 24'h000000;
         dstPtr_q  <= 24'h000000;
         pairCnt_q <= 16'h0000;
         done_q    <= 1'b0;
         state_q   <= ST_IDLE;
         pend_q    <= 1'b0;
         fromRx_q  <= 1'b0;
         extSync_q <= 3'h7;
         extLvl_q  <= 1'b1;
         busReq    <= 1'b0;
         memReq    <= 1'b0;
         memWrite  <= 1'b0;
         memWord   <= 1'b0;
         memAddr   <= 24'h000000;
         memWdata  <= 16'h0000;
         irqReq    <= 1'b0;
      end else begin
         extSync_q <= {extSync_q[1:0], extReq_n};
         if (extSync_q[2] == extSync_q[1])
            extLvl_q <= extSync_q[2];
         // pending set wins over the clear at transfer start
         if (en && trig)
            pend_q <= 1'b1;
         else if (startXfer || !en)
            pend_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (en && pend_q) begin
                  busReq  <= 1'b1;
                  state_q <= ST_ARB;
               end
            end
            ST_ARB: begin
               if (busGrant) begin
                  fromRx_q <= rep && srcSel == `DMAREP_SRC_RX;
                  memReq   <= 1'b1;
                  memWrite <= 1'b0;
                  memWord  <= word;
                  if (!rep)
                     memAddr <= srcPtr_q;
                  else if (srcSel == `DMAREP_SRC_RX)
                     memAddr <= ioAddr;
                  else
                     memAddr <= memPtr_q;
                  state_q <= ST_RD;
               end
            end
            ST_RD: begin
               if (memAck) begin
                  memWrite <= 1'b1;
                  memWdata <= memRdata;
                  if (!rep)
                     memAddr <= dstPtr_q;
                  else if (fromRx_q)
                     memAddr <= memPtr_q;
                  else
                     memAddr <= ioAddr;
                  state_q <= ST_WR;
               end
            end
            ST_WR: begin
               if (memAck) begin
                  // one item per request, then bookkeeping
                  memReq   <= 1'b0;
                  memWrite <= 1'b0;
                  if (rep) begin
                     if (liveCnt_q == 8'h01) begin
                        liveCnt_q <= initCnt_q;
                        // restore so the next cycle reuses the table
                        if (ctrl_q[`DMAREP_CTL_DEC])
                           memPtr_q <= stepPtr(memPtr_q, repStep, word) +
                              ({16'h0000, initCnt_q} << word);
                        else
                           memPtr_q <= stepPtr(memPtr_q, repStep, word) -
                              ({16'h0000, initCnt_q} << word);
                     end else begin
                        liveCnt_q <= liveCnt_q - 8'h01;
                        memPtr_q  <= stepPtr(memPtr_q, repStep, word);
                     end
                  end else begin
                     srcPtr_q <= stepPtr(srcPtr_q,
                        ctrl_q[`DMAREP_CTL_SST_HI:`DMAREP_CTL_SST_LO],
                        word);
                     dstPtr_q <= stepPtr(dstPtr_q,
                        ctrl_q[`DMAREP_CTL_DST_HI:`DMAREP_CTL_DST_LO],
                        word);
                     // zero start wraps to ffff: full 65536 run
                     pairCnt_q <= pairCnt_q - 16'h0001;
                     if (normEnd) begin
                        ctrl_q[`DMAREP_CTL_EN] <= 1'b0;
                        done_q <= 1'b1;
                     end
                  end
                  if (stayBus) begin
                     state_q <= ST_ARB;
                  end else begin
                     busReq  <= 1'b0;
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
         // software writes; done clears on write-1 unless set now
         if (doWrite && wrHit) begin
            case (awAddr_q)
               `DMAREP_OFS_CTRL:
                  ctrl_q <= ctlM[`DMAREP_CTL_W-1:0];
               `DMAREP_OFS_MEMPTR:  memPtr_q <= memM[23:0];
               `DMAREP_OFS_IOLOW:   if (wStrb_q[0]) ioLow_q <= wData_q[7:0];
               `DMAREP_OFS_LIVECNT: if (wStrb_q[0]) liveCnt_q <= wData_q[7:0];
               `DMAREP_OFS_INITCNT: if (wStrb_q[0]) initCnt_q <= wData_q[7:0];
               `DMAREP_OFS_SRCPTR:  srcPtr_q <= srcM[23:0];
               `DMAREP_OFS_DSTPTR:  dstPtr_q <= dstM[23:0];
               `DMAREP_OFS_PAIRCNT: pairCnt_q <= cntM[15:0];
               `DMAREP_OFS_STATUS:
                  if (wStrb_q[0] && wData_q[`DMAREP_ST_DONE] &&
                      !(lastDone && normEnd))
                     done_q <= 1'b0;
               default: ;
            endcase
         end
         // repeat never flags completion
         irqReq <= done_q && ctrl_q[`DMAREP_CTL_IRQEN] && !rep;
      end
   end

endmodule // dmarep_channel

`default_nettype wire

// ### tb/dmarep_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dmarep_assertions (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        busReq,
   input wire logic        busGrant,
   input wire logic        hiPriReq,
   input wire logic        memReq,
   input wire logic        memWrite,
   input wire logic        memAck,
   input wire logic [23:0] memAddr
);
   // ***************
   // item sequencing
   // ***************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_rd_done;
      memReq && memAck && !memWrite;
   endsequence
   sequence s_wr_done;
      memReq && memAck && memWrite;
   endsequence
   a_mem_hold: assert property (
      memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite))
      else $error("memory request changed before ack");
   a_read_then_write: assert property (s_rd_done |=> memReq && memWrite)
      else $error("read not followed by write");
   a_write_ends: assert property (s_wr_done |=> !memReq)
      else $error("request held after write ack");
   a_bus_owned: assert property (memReq |-> busReq)
      else $error("memory cycle without bus request");
   a_grant_first: assert property ($rose(memReq) |-> $past(busGrant))
      else $error("memory cycle before grant");
   a_yield_hipri: assert property (s_wr_done ##0 hiPriReq |=> !busReq)
      else $error("bus kept against higher master");
   a_bresp_stands: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read accepted");
endmodule // dmarep_assertions
bind dmarep_channel dmarep_assertions u_chk (
   .clk(clk), .arst_n(arst_n), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .busReq(busReq), .busGrant(busGrant),
   .hiPriReq(hiPriReq), .memReq(memReq), .memWrite(memWrite),
   .memAck(memAck), .memAddr(memAddr));
`default_nettype wire

// ### tb/dmarep_sysbus.sv
`timescale 1ns/1ps
`default_nettype none
module dmarep_sysbus (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        busReq,
   input wire logic        memReq,
   input wire logic        slowAck,
   input wire logic [23:0] memAddr,
   output logic            busGrant,
   output logic            memAck,
   output logic [15:0]     memRdata
);
   logic [2:0] waitCnt;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busGrant <= 1'b0;
         memAck <= 1'b0;
         waitCnt <= 3'h0;
         memRdata <= 16'h0;
      end else begin
         busGrant <= busReq;
         if (memReq && !memAck && waitCnt >= (slowAck ? 3'h3 : 3'h0)) begin
            memAck <= 1'b1;
            waitCnt <= 3'h0;
            memRdata <= memAddr[15:0] ^ 16'h5a5a;
         end else begin
            memAck <= 1'b0;
            waitCnt <= (memReq && !memAck) ? waitCnt + 3'h1 : 3'h0;
            // no stale data between acks
            memRdata <= ~memRdata;
         end
      end
   end
endmodule // dmarep_sysbus
`default_nettype wire

// ### tb/tb_dma_repeat_and_dual_address.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmarep_defines.vh"
module tb_dma_repeat_and_dual_address;
   logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb, timerMatch;
   logic        txEmpty, rxFull, extReq_n, hiPriReq, slowAck;
   wire         awready, wready, bvalid, arready, rvalid, busReq, busGrant;
   wire         memReq, memWrite, memWord, memAck, irqReq;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [23:0] memAddr;
   wire  [15:0] memWdata, memRdata;
   logic [24:0] logA[$];
   logic [15:0] logD[$];
   int          n_mismatch, cmp_count, busFalls;
   dmarep_channel dut_u (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timerMatch(timerMatch), .txEmpty(txEmpty),
      .rxFull(rxFull), .extReq_n(extReq_n), .busReq(busReq),
      .busGrant(busGrant), .hiPriReq(hiPriReq), .memReq(memReq),
      .memWrite(memWrite), .memWord(memWord), .memAddr(memAddr),
      .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
      .irqReq(irqReq));
   dmarep_sysbus bus_u (.clk(clk), .arst_n(arst_n), .busReq(busReq),
      .memReq(memReq), .slowAck(slowAck), .memAddr(memAddr),
      .busGrant(busGrant), .memAck(memAck), .memRdata(memRdata));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (memReq && memAck) begin
         logA.push_back({memWrite, memAddr});
         logD.push_back(memWdata);
      end
   end
   always @(negedge busReq) busFalls++;
   // *************
   // bench helpers
   // *************
   task end_of_test;
      $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t %s", $time, m);
      end
   endtask
   task tmo(input int n);
      if (n >= 300) begin
         chk(32'h0, 32'h1, "wait timed out");
         end_of_test;
      end
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic ta, tw;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      {awvalid, wvalid, bready} <= 3'b111;
      {ta, tw} = 2'b00;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (awready && !ta) {ta, awvalid} <= 2'b10;
         if (wready && !tw) {tw, wvalid} <= 2'b10;
      end while (!bvalid && n < 300);
      tmo(n);
      r = bresp;
      bready <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e, input string m);
      int n;
      logic t;
      @(posedge clk);
      araddr <= a;
      {arvalid, rready, t} <= 3'b110;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (arready && !t) {t, arvalid} <= 2'b10;
      end while (!rvalid && n < 300);
      tmo(n);
      chk(rdata, e, m);
      chk({30'h0, rresp}, {30'h0, a > 8'h20 ? 2'h2 : 2'h0}, "read resp");
      rready <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axw(a, d, r);
      chk({30'h0, r}, {30'h0, a > 8'h20 ? 2'h2 : 2'h0}, "write resp");
   endtask
   task pulse(input int s);
      @(posedge clk);
      if (s < 4) timerMatch <= 4'h1 << s;
      else if (s == 4) txEmpty <= 1'b1;
      else if (s == 5) rxFull <= 1'b1;
      else extReq_n <= 1'b0;
      // ext goes through a three-stage synchroniser
      repeat (s == 6 ? 5 : 1) @(posedge clk);
      {timerMatch, txEmpty, rxFull, extReq_n} <= 7'h01;
   endtask
   task wlog(input int k);
      int n;
      n = 0;
      while (logA.size() < k && n < 300) begin
         @(posedge clk);
         n++;
      end
      tmo(n);
   endtask
   task item(input int j, input logic [23:0] ra, input logic [23:0] wa);
      chk({7'h0, logA[2*j]}, {8'h0, ra}, "read address");
      chk({7'h0, logA[2*j+1]}, {7'h0, 1'b1, wa}, "write address");
   endtask
   task setn(input logic [31:0] cnt);
      logA.delete();
      logD.delete();
      wr(`DMAREP_OFS_SRCPTR, 32'h003000);
      wr(`DMAREP_OFS_DSTPTR, 32'h004000);
      wr(`DMAREP_OFS_PAIRCNT, cnt);
      busFalls = 0;
   endtask
   // *********
   // scenarios
   // *********
   task t_regs;
      rdc(`DMAREP_OFS_CTRL, 32'h0, "control reset");
      wr(`DMAREP_OFS_MEMPTR, 32'hffffffff);
      rdc(`DMAREP_OFS_MEMPTR, 32'h00ffffff, "pointer width");
      wr(`DMAREP_OFS_IOLOW, 32'h1ab);
      rdc(`DMAREP_OFS_IOLOW, 32'hab, "io low width");
      rdc(8'h24, 32'h0, "unmapped read");
      wr(8'h30, 32'h1);
      $display("t_regs done");
   endtask
   task t_sources;
      logic [23:0] m;
      logA.delete();
      wr(`DMAREP_OFS_MEMPTR, 32'h001000);
      wr(`DMAREP_OFS_IOLOW, 32'h5c);
      wr(`DMAREP_OFS_LIVECNT, 32'hff);
      wr(`DMAREP_OFS_INITCNT, 32'hff);
      for (int i = 0; i < 7; i++) begin
         wr(`DMAREP_OFS_CTRL, 32'h11 | (i << 5));
         pulse(i);
         wlog(2 * i + 2);
         m = 24'h001000 + 24'(i);
         if (i == 5) item(i, 24'hffff5c, m);
         else item(i, m, 24'hffff5c);
      end
      wr(`DMAREP_OFS_CTRL, 32'hf1);
      repeat (20) @(posedge clk);
      chk(logA.size(), 32'd14, "auto ran in repeat");
      rdc(`DMAREP_OFS_LIVECNT, 32'hf8, "live count");
      wr(`DMAREP_OFS_CTRL, 32'h0);
      $display("t_sources done");
   endtask
   task t_reload;
      logA.delete();
      wr(`DMAREP_OFS_MEMPTR, 32'h002010);
      wr(`DMAREP_OFS_IOLOW, 32'h40);
      wr(`DMAREP_OFS_LIVECNT, 32'h2);
      wr(`DMAREP_OFS_INITCNT, 32'h2);
      wr(`DMAREP_OFS_CTRL, 32'h9d);
      for (int i = 0; i < 3; i++) begin
         pulse(4);
         wlog(2 * i + 2);
      end
      item(0, 24'h002010, 24'hffff40);
      item(1, 24'h00200e, 24'hffff40);
      item(2, 24'h002010, 24'hffff40);
      wr(`DMAREP_OFS_CTRL, 32'h9c);
      pulse(4);
      repeat (20) @(posedge clk);
      chk(logA.size(), 32'd6, "disabled channel moved");
      rdc(`DMAREP_OFS_LIVECNT, 32'h1, "count kept");
      rdc(`DMAREP_OFS_MEMPTR, 32'h00200e, "pointer kept");
      wr(`DMAREP_OFS_CTRL, 32'h9d);
      pulse(4);
      wlog(8);
      item(3, 24'h00200e, 24'hffff40);
      chk({31'h0, irqReq}, 32'h0, "repeat raised irq");
      wr(`DMAREP_OFS_CTRL, 32'h0);
      $display("t_reload done");
   endtask
   task t_normal;
      logic [23:0] m;
      slowAck <= 1'b1;
      setn(32'h3);
      wr(`DMAREP_OFS_CTRL, 32'h13e7);
      wlog(6);
      for (int i = 0; i < 3; i++) begin
         m = 24'h003000 + 24'(2 * i);
         item(i, m, 24'h004000 - 24'(2 * i));
         chk({16'h0, logD[2*i+1]}, {16'h0, m[15:0] ^ 16'h5a5a}, "data");
      end
      rdc(`DMAREP_OFS_CTRL, 32'h13e6, "enable not cleared");
      chk({31'h0, irqReq}, 32'h1, "no completion irq");
      chk(logA.size(), 32'd6, "extra transfers");
      chk(busFalls, 32'd1, "burst released bus");
      chk({31'h0, memWord}, 32'h1, "item size");
      wr(`DMAREP_OFS_STATUS, 32'h1);
      @(posedge clk);
      chk({31'h0, irqReq}, 32'h0, "irq not cleared");
      slowAck <= 1'b0;
      $display("t_normal done");
   endtask
   task t_steal;
      for (int m = 0; m < 2; m++) begin
         setn(32'h2);
         hiPriReq <= m[0];
         wr(`DMAREP_OFS_CTRL, m ? 32'h1e1 : 32'he1);
         wlog(4);
         item(0, 24'h003000, 24'h004000);
         item(1, 24'h003000, 24'h004000);
         rdc(`DMAREP_OFS_PAIRCNT, 32'h0, "count at end");
         chk(busFalls, 32'd2, "bus not released");
         chk({31'h0, irqReq}, 32'h0, "irq while disabled");
         hiPriReq <= 1'b0;
      end
      $display("t_steal done");
   endtask
   task t_ext_zero;
      setn(32'h0);
      wr(`DMAREP_OFS_CTRL, 32'hac1);
      pulse(0);
      pulse(4);
      pulse(5);
      repeat (20) @(posedge clk);
      chk(logA.size(), 32'd0, "normal took timer or serial");
      pulse(6);
      wlog(2);
      item(0, 24'h003000, 24'h004000);
      rdc(`DMAREP_OFS_PAIRCNT, 32'hffff, "count from zero");
      rdc(`DMAREP_OFS_CTRL, 32'hac1, "stopped early");
      wr(`DMAREP_OFS_CTRL, 32'h0);
      $display("t_ext_zero done");
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      {timerMatch, txEmpty, rxFull, extReq_n, hiPriReq, slowAck} = 9'h04;
      {n_mismatch, cmp_count, busFalls} = 96'h0;
      arst_n = 1'b0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_regs;
      t_sources;
      t_reload;
      t_normal;
      t_steal;
      t_ext_zero;
      end_of_test;
   end
endmodule // tb_dma_repeat_and_dual_address
`default_nettype wire
